//--- include/pmr_pkg.sv
// ***************************************************************
// Constants for the power mode, wake and reset controller
// ***************************************************************
package pmr_pkg;

   // Number of user I/O pins
   localparam int NPIN          = 4;
   // Core clock
   localparam int CLK_PERIOD_NS = 5;
   // Start-up timeout after the supervisor clears, in microseconds
   localparam int TIMEOUT_US    = 1000;
   localparam int TIMEOUT_CYC   = (TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // User I/O pin functions
   typedef enum logic [2:0] {
      FN_INPUT,
      FN_OUTPUT,
      FN_SLEEP,
      FN_SLEEP_N,
      FN_WAKE,
      FN_WAKE_N
   } pmr_fn_t;
   localparam int FN_W = 3;

   // Power supervisor configuration fields
   localparam int PSC_RESET_OUTPUT_ENABLE   = 0;
   localparam int PSC_CPE    = 1;
   localparam int PSC_SUPE   = 2;
   localparam int PSC_OSC32E = 3;
   localparam int PSC_WAKEE  = 4;
   localparam int PSC_W      = 5;
   localparam logic [PSC_W-1:0] PSC_RST = 5'h1d;

   // Analog block enables and converter mode
   localparam int AN_ADC     = 0;
   localparam int AN_PUMP    = 1;
   localparam int AN_REF     = 2;
   localparam int AN_OPAMP   = 3;
   localparam int AN_DAC     = 4;
   localparam int AN_SW      = 5;
   localparam int AN_BIPOLAR = 6;
   localparam int AN_NBLK    = 6;
   localparam int AN_W       = 7;
   localparam logic [AN_W-1:0] AN_RST = 7'h00;

   // Status flags and interrupt mask
   localparam int ST_HFRDY = 0;
   localparam int ST_LOWDV = 1;
   localparam int ST_WAKE  = 2;
   localparam int ST_W     = 3;
   localparam logic [ST_W-1:0] MASK_RST = 3'h1;

   // Converter code formats
   localparam int ADC_W  = 16;
   localparam int ADC_IW = 17;
   localparam logic [ADC_W-1:0] UNI_ZERO = 16'h0000;

endpackage

//--- include/pmr_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Synchronised levels and edges of asynchronous inputs
// ***************************************************************
interface pmr_sync_if #(parameter int W = 1);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

//--- sim/pmr_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD %0t value mismatch", $time); end end
module pmr_ctrl_tb_top;
   import pmr_pkg::*;
   logic i_core_clk, i_rstn, i_dvdd_low, i_slow_clock_ready, i_xtal_attach;
   logic i_watchdog_expired, i_day_alarm, i_hf_clock_ready, i_sleep_cmd_wr, i_normal_cmd_wr;
   logic i_sleep_cfg_wr, i_sleep_request_bit, i_psc_wr, i_analog_wr, i_pin_cfg_wr;
   logic i_mask_wr, i_status_rd, i_adc_vld, drv_en;
   logic [PSC_W-1:0] i_psc_wdata, o_power_supervisor_config;
   logic [AN_W-1:0] i_analog_wdata;
   logic [NPIN-1:0][FN_W-1:0] i_pin_fn_wdata;
   logic [NPIN-1:0] i_pin_out_wdata, i_pin_rail_wdata, o_pin_o, o_pin_oe, drv_val;
   logic [NPIN-1:0] o_pin_pullup, o_pin_avdd_rail;
   wire  [NPIN-1:0] i_user_io_pin;
   logic [ST_W-1:0] i_mask_wdata, o_status;
   logic signed [ADC_IW-1:0] i_adc_value;
   logic o_sleep, o_shutdown_flag, o_reset_n, o_irq, o_supervisor_on, o_slow_osc_on;
   logic o_wake_logic_on, o_clk_out_en, o_slow_clock_out_en, o_adc_vld;
   logic [AN_NBLK-1:0] o_analog_on;
   logic [ADC_W-1:0] o_adc_code;
   int fail_count, total_checks, cyc;
   // 200 MHz core clock
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   pmr_ctrl #(.P_TIMEOUT_CYC(8)) uut (.*);
   pmr_host_model host (.i_pin_oe(o_pin_oe), .i_pin_o(o_pin_o), .i_pin_pullup(o_pin_pullup),
      .i_drv_en(drv_en), .i_drv_val(drv_val), .o_pin(i_user_io_pin));
   // Hang guard, well beyond the hundred or so cycles the tests need
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   // Idle cycle after the strobe so the next pulse never lands in the same step
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   task automatic t_defaults;
      `CHK(o_clk_out_en, 1'b0)
      `CHK(o_pin_oe, 4'h0)
      `CHK(o_pin_pullup, 4'hf)
      `CHK(o_supervisor_on, 1'b1)
      `CHK(o_analog_on, 6'h00)
      `CHK(o_power_supervisor_config, 5'h1d)
      `CHK(o_reset_n, 1'b1)
      pulse(i_hf_clock_ready);
      `CHK(o_irq, 1'b1)
      pulse(i_status_rd);
      pulse(i_day_alarm);
      `CHK(o_status[ST_WAKE], 1'b1)
      `CHK(o_sleep, 1'b0)
      `CHK(o_irq, 1'b0)
      `CHK({o_clk_out_en, o_slow_clock_out_en, o_slow_osc_on}, 3'h7)
      $display("defaults done");
   endtask
   task automatic t_sleep;
      i_analog_wdata = 7'h3f;
      pulse(i_analog_wr);
      `CHK(o_analog_on, 6'h3f)
      pulse(i_sleep_cmd_wr);
      `CHK({o_sleep, o_shutdown_flag}, 2'b11)
      `CHK({o_analog_on, o_wake_logic_on, o_clk_out_en}, 8'h02)
      pulse(i_normal_cmd_wr);
      `CHK({o_sleep, o_shutdown_flag}, 2'b00)
      i_sleep_request_bit = 1'b1;
      pulse(i_sleep_cfg_wr);
      `CHK({o_sleep, o_shutdown_flag}, 2'b11)
      pulse(i_day_alarm);
      `CHK({o_sleep, o_shutdown_flag}, 2'b00)
      $display("sleep commands done");
   endtask
   // Host drives the pin low before giving it the sleep function
   task automatic t_pin_sleep;
      drv_en = 1'b1;
      tick(2);
      i_pin_fn_wdata[0] = FN_SLEEP;
      pulse(i_pin_cfg_wr);
      drv_val[0] = 1'b1;
      tick(4);
      `CHK({o_sleep, o_shutdown_flag}, 2'b10)
      pulse(i_normal_cmd_wr);
      `CHK(o_sleep, 1'b1)
      drv_val[0] = 1'b0;
      tick(4);
      `CHK(o_sleep, 1'b0)
      $display("pin sleep done");
   endtask
   // Output, wake and inverted sleep pin functions, pump rail and supply monitor
   task automatic t_pin_wake;
      drv_val = 4'hc;
      tick(2);
      i_pin_fn_wdata = {FN_WAKE_N, FN_SLEEP_N, FN_WAKE, FN_OUTPUT};
      {i_pin_out_wdata, i_pin_rail_wdata} = 8'h11;
      pulse(i_pin_cfg_wr);
      `CHK({o_pin_oe, o_pin_o, o_pin_avdd_rail, o_pin_pullup}, 16'h111e)
      i_psc_wdata = 5'h1f;
      pulse(i_psc_wr);
      `CHK(o_pin_avdd_rail, 4'h0)
      pulse(i_sleep_cmd_wr);
      `CHK(o_sleep, 1'b1)
      drv_val = 4'he;
      tick(4);
      `CHK({o_sleep, o_shutdown_flag}, 2'b00)
      pulse(i_sleep_cmd_wr);
      `CHK(o_sleep, 1'b1)
      drv_val = 4'h6;
      tick(4);
      `CHK({o_sleep, o_shutdown_flag}, 2'b00)
      drv_val = 4'h2;
      tick(4);
      `CHK({o_sleep, o_shutdown_flag}, 2'b10)
      pulse(i_day_alarm);
      `CHK(o_sleep, 1'b1)
      drv_val = 4'h6;
      tick(4);
      `CHK(o_sleep, 1'b0)
      // Low supply pulls reset while enabled, else only interrupts
      i_dvdd_low = 1'b1;
      i_mask_wdata = 3'h2;
      pulse(i_mask_wr);
      tick(2);
      `CHK({o_reset_n, o_irq, o_status[ST_LOWDV]}, 3'b001)
      i_psc_wdata = 5'h1e;
      pulse(i_psc_wr);
      `CHK({o_reset_n, o_irq, o_status[ST_LOWDV]}, 3'b111)
      i_dvdd_low = 1'b0;
      tick(3);
      $display("pin functions and supply done");
   endtask
   task automatic t_reset_adc;
      i_watchdog_expired = 1'b1;
      tick(3);
      `CHK(o_reset_n, 1'b0)
      i_watchdog_expired = 1'b0;
      i_adc_value = -17'sd2; // Unipolar, as a supply measurement needs
      i_adc_vld = 1'b1;
      tick(1);
      `CHK({o_adc_vld, o_adc_code}, 17'h10000)
      i_adc_vld = 1'b0;
      tick(1);
      i_adc_value = 17'sh0ffff;
      pulse(i_adc_vld);
      `CHK(o_adc_code, 16'hffff)
      i_analog_wdata = 7'h40; // Bipolar; host keeps DAC codes offset binary
      pulse(i_analog_wr);
      i_adc_value = -17'sh10000;
      pulse(i_adc_vld);
      `CHK(o_adc_code, 16'h8000)
      `CHK(o_reset_n, 1'b1)
      $display("reset and converter done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      {i_dvdd_low, i_xtal_attach, i_watchdog_expired, i_day_alarm, i_hf_clock_ready} = '0;
      {i_sleep_cmd_wr, i_normal_cmd_wr, i_sleep_cfg_wr, i_sleep_request_bit, i_psc_wr} = '0;
      {i_analog_wr, i_pin_cfg_wr, i_mask_wr, i_status_rd, i_adc_vld, drv_en} = '0;
      {i_psc_wdata, i_analog_wdata, i_pin_fn_wdata, i_pin_out_wdata} = '0;
      {i_pin_rail_wdata, i_mask_wdata, i_adc_value, drv_val} = '0;
      i_slow_clock_ready = 1'b1;
      i_rstn = 1'b0;
      tick(4);
      i_rstn = 1'b1;
      tick(5);
      t_defaults();
      t_sleep();
      t_pin_sleep();
      t_pin_wake();
      t_reset_adc();
      report_and_stop();
   end
endmodule
`default_nettype wire

//--- sim/pmr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the user pins
module pmr_host_model (
   // Device pin controls
   input  wire logic [pmr_pkg::NPIN-1:0] i_pin_oe,
   input  wire logic [pmr_pkg::NPIN-1:0] i_pin_o,
   input  wire logic [pmr_pkg::NPIN-1:0] i_pin_pullup,
   // Host drive
   input  wire logic                     i_drv_en,
   input  wire logic [pmr_pkg::NPIN-1:0] i_drv_val,
   // Resolved pin level
   output logic [pmr_pkg::NPIN-1:0]      o_pin
);
   import pmr_pkg::*;
   // Host raises and drops pin functions; an undriven pin without pull-up shows a wrong level
   assign o_pin = (i_pin_oe & i_pin_o) |
                  (~i_pin_oe & (i_drv_en ? i_drv_val : (i_pin_pullup | ~i_pin_o)));
endmodule
`default_nettype wire

//--- verilog/pmr_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Power mode, sleep / wake and reset output controller
// ***************************************************************
module pmr_ctrl #(
   parameter int P_TIMEOUT_CYC = pmr_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                                 i_core_clk,
   input  wire logic                                 i_rstn,
   // Asynchronous pins and monitors
   input  wire logic [pmr_pkg::NPIN-1:0]             i_user_io_pin,
   input  wire logic                                 i_dvdd_low,
   input  wire logic                                 i_slow_clock_ready,
   input  wire logic                                 i_xtal_attach,
   // Same-clock events
   input  wire logic                                 i_watchdog_expired,
   input  wire logic                                 i_day_alarm,
   input  wire logic                                 i_hf_clock_ready,
   // Host commands
   input  wire logic                                 i_sleep_cmd_wr,
   input  wire logic                                 i_normal_cmd_wr,
   input  wire logic                                 i_sleep_cfg_wr,
   input  wire logic                                 i_sleep_request_bit,
   input  wire logic                                 i_psc_wr,
   input  wire logic [pmr_pkg::PSC_W-1:0]            i_psc_wdata,
   input  wire logic                                 i_analog_wr,
   input  wire logic [pmr_pkg::AN_W-1:0]             i_analog_wdata,
   input  wire logic                                 i_pin_cfg_wr,
   input  wire logic [pmr_pkg::NPIN-1:0][pmr_pkg::FN_W-1:0] i_pin_fn_wdata,
   input  wire logic [pmr_pkg::NPIN-1:0]             i_pin_out_wdata,
   input  wire logic [pmr_pkg::NPIN-1:0]             i_pin_rail_wdata,
   input  wire logic                                 i_mask_wr,
   input  wire logic [pmr_pkg::ST_W-1:0]             i_mask_wdata,
   input  wire logic                                 i_status_rd,
   // Converter data
   input  wire logic                                 i_adc_vld,
   input  wire logic signed [pmr_pkg::ADC_IW-1:0]    i_adc_value,
   // Mode and reset
   output logic                                      o_sleep,
   output logic                                      o_shutdown_flag,
   output logic                                      o_reset_n,
   output logic                                      o_irq,
   output logic [pmr_pkg::ST_W-1:0]                  o_status,
   output logic [pmr_pkg::PSC_W-1:0]                 o_power_supervisor_config,
   // Power enables and clock outputs
   output logic [pmr_pkg::AN_NBLK-1:0]               o_analog_on,
   output logic                                      o_supervisor_on,
   output logic                                      o_slow_osc_on,
   output logic                                      o_wake_logic_on,
   output logic                                      o_clk_out_en,
   output logic                                      o_slow_clock_out_en,
   // User I/O pins
   output logic [pmr_pkg::NPIN-1:0]                  o_pin_o,
   output logic [pmr_pkg::NPIN-1:0]                  o_pin_oe,
   output logic [pmr_pkg::NPIN-1:0]                  o_pin_pullup,
   output logic [pmr_pkg::NPIN-1:0]                  o_pin_avdd_rail,
   // Converter code
   output logic                                      o_adc_vld,
   output logic [pmr_pkg::ADC_W-1:0]                 o_adc_code
);
   import pmr_pkg::*;

   localparam int CW = $clog2(P_TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] TMO_LAST = CW'(P_TIMEOUT_CYC - 1);
   localparam logic [CW-1:0] TMO_ONE  = CW'(1);
   localparam int SW = NPIN + 3;
   localparam logic [SW-1:0] SYNC_RST = {3'h0, {NPIN{1'b1}}};

   typedef enum logic {MODE_NORMAL, MODE_SLEEP} pmr_mode_t;
   typedef enum logic [1:0] {CK_WAIT, CK_COUNT, CK_RUN} pmr_ck_t;

   // ***************************************************************
   // Decoding helpers
   // ***************************************************************
   function automatic logic fn_sleep(input logic [FN_W-1:0] fn, input logic lvl);
      fn_sleep = (fn == FN_SLEEP && lvl) || (fn == FN_SLEEP_N && !lvl);
   endfunction

   function automatic logic fn_wake(input logic [FN_W-1:0] fn, input logic r, input logic f);
      fn_wake = (fn == FN_WAKE && r) || (fn == FN_WAKE_N && f);
   endfunction

   // ***************************************************************
   // Input synchronisation
   // ***************************************************************
   pmr_sync_if #(.W(SW)) sync_bus ();

   pmr_sync_edge #(
      .W       (SW),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_async    ({i_xtal_attach, i_slow_clock_ready, i_dvdd_low, i_user_io_pin}),
      .o_sync     (sync_bus)
   );

   logic low_s;
   logic slow_s;
   logic xtal_s;
   assign low_s  = sync_bus.lvl[NPIN];
   assign slow_s = sync_bus.lvl[NPIN+1];
   assign xtal_s = sync_bus.lvl[NPIN+2];

   // ***************************************************************
   // Configuration state
   // ***************************************************************
   logic [PSC_W-1:0]           psc_ff;
   logic [AN_W-1:0]            an_ff;
   logic [NPIN-1:0][FN_W-1:0]  fn_ff;
   logic [NPIN-1:0]            pout_ff;
   logic [NPIN-1:0]            rail_ff;
   logic [ST_W-1:0]            mask_ff;

   // All pins inputs, supervisor and reset output on, analog off
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         psc_ff  <= PSC_RST;
         an_ff   <= AN_RST;
         fn_ff   <= {NPIN{FN_INPUT}};
         pout_ff <= '0;
         rail_ff <= '0;
         mask_ff <= MASK_RST;
      end else begin
         if (i_psc_wr) psc_ff <= i_psc_wdata;
         if (i_analog_wr) an_ff <= i_analog_wdata;
         if (i_mask_wr) mask_ff <= i_mask_wdata;
         if (i_pin_cfg_wr) begin
            fn_ff   <= i_pin_fn_wdata;
            pout_ff <= i_pin_out_wdata;
            rail_ff <= i_pin_rail_wdata;
         end
      end
   end

   // ***************************************************************
   // Per-pin decode
   // ***************************************************************
   logic [NPIN-1:0] pin_sleep;
   logic [NPIN-1:0] pin_wake;
   logic [NPIN-1:0] pin_drv;

   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_pin
         // Either polarity of the sleep and wake functions is honoured
         assign pin_sleep[i] = fn_sleep(fn_ff[i], sync_bus.lvl[i]);
         assign pin_wake[i]  = fn_wake(fn_ff[i], sync_bus.rise[i], sync_bus.fall[i]);
         assign pin_drv[i]   = (fn_ff[i] == FN_OUTPUT);
      end
   endgenerate

   // ***************************************************************
   // Sleep and wake control
   // ***************************************************************
   pmr_mode_t mode_ff;
   pmr_mode_t nxt_mode;
   logic      shutdown_flag_ff;
   logic      nxt_shutdown_flag;
   logic      pin_sleep_w;
   logic      set_req;
   logic      clr_req;
   logic      wake_evt;

   assign pin_sleep_w = |pin_sleep;
   // Wake sources only count while the wake logic is enabled
   assign wake_evt = psc_ff[PSC_WAKEE] & ((|pin_wake) | i_day_alarm);
   assign set_req  = i_sleep_cmd_wr | (i_sleep_cfg_wr & i_sleep_request_bit);
   // Pin sleep blocks software clears and wakes; flag left as it is
   assign clr_req  = ~pin_sleep_w & (i_normal_cmd_wr | (wake_evt & o_sleep));
   // A set in the same cycle as a clear wins, so a sleep request is never lost
   assign nxt_shutdown_flag = set_req | (shutdown_flag_ff & ~clr_req);
   // Sleep is the OR of the pin function and the flag
   assign nxt_mode = (nxt_shutdown_flag | pin_sleep_w) ? MODE_SLEEP : MODE_NORMAL;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         shutdown_flag_ff <= 1'b0;
         mode_ff <= MODE_NORMAL;
      end else begin
         shutdown_flag_ff <= nxt_shutdown_flag;
         mode_ff <= nxt_mode;
      end
   end

   assign o_sleep         = (mode_ff == MODE_SLEEP);
   assign o_shutdown_flag = shutdown_flag_ff;

   // ***************************************************************
   // Status flags and interrupt request
   // ***************************************************************
   logic [ST_W-1:0] status_ff;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] nxt_status;
   logic [ST_W-1:0] mask_eff;
   logic            irq_ff;

   // Wake in either mode is recorded; a persisting low supply re-sets at once
   assign st_set[ST_HFRDY] = i_hf_clock_ready;
   assign st_set[ST_LOWDV] = low_s & psc_ff[PSC_SUPE];
   assign st_set[ST_WAKE]  = wake_evt;
   assign nxt_status = (status_ff & ~{ST_W{i_status_rd}}) | st_set;
   // Low supply interrupts only when the reset output is not used for it
   assign mask_eff = mask_ff & ~(psc_ff[PSC_RESET_OUTPUT_ENABLE] ? {{(ST_W-1){1'b0}}, 1'b1} << ST_LOWDV : '0);

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         status_ff <= '0;
         irq_ff    <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff    <= |(status_ff & mask_eff);
      end
   end

   assign o_status = status_ff;
   assign o_irq    = irq_ff;
   assign o_power_supervisor_config = psc_ff;

   // ***************************************************************
   // Reset output
   // ***************************************************************
   logic por_ff;
   logic rst_n_ff;
   logic nxt_rst_n;

   // Enable bit set lets the supply detector pull reset; polarity taken this way
   assign nxt_rst_n = ~(por_ff | (low_s & psc_ff[PSC_RESET_OUTPUT_ENABLE] & psc_ff[PSC_SUPE]) |
                        i_watchdog_expired | xtal_s | ~slow_s);

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         por_ff   <= 1'b1;
         rst_n_ff <= 1'b0;
      end else begin
         por_ff   <= 1'b0;
         rst_n_ff <= nxt_rst_n;
      end
   end

   assign o_reset_n = rst_n_ff;

   // ***************************************************************
   // Clock output start-up
   // ***************************************************************
   pmr_ck_t       ck_ff;
   pmr_ck_t       nxt_ck;
   logic [CW-1:0] tmo_ff;
   logic [CW-1:0] nxt_tmo;
   logic          sup_clear;
   logic          clk_en_ff;
   logic          slow_en_ff;

   // A disabled supervisor counts as cleared
   assign sup_clear = ~(low_s & psc_ff[PSC_SUPE]);

   // Count restarts whenever the supervisor trips again during start-up
   always_comb begin
      nxt_ck  = ck_ff;
      nxt_tmo = tmo_ff;
      case (ck_ff)
         CK_WAIT: begin
            nxt_tmo = '0;
            if (sup_clear) nxt_ck = CK_COUNT;
         end
         CK_COUNT: begin
            nxt_tmo = tmo_ff + TMO_ONE;
            if (!sup_clear) nxt_ck = CK_WAIT;
            else if (tmo_ff == TMO_LAST) nxt_ck = CK_RUN;
         end
         CK_RUN: nxt_ck = CK_RUN;
         default: nxt_ck = CK_WAIT;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ck_ff      <= CK_WAIT;
         tmo_ff     <= '0;
         clk_en_ff  <= 1'b0;
         slow_en_ff <= 1'b0;
      end else begin
         ck_ff      <= nxt_ck;
         tmo_ff     <= nxt_tmo;
         clk_en_ff  <= (ck_ff == CK_RUN) & (nxt_mode == MODE_NORMAL);
         slow_en_ff <= (ck_ff == CK_RUN) & psc_ff[PSC_OSC32E];
      end
   end

   assign o_clk_out_en        = clk_en_ff;
   assign o_slow_clock_out_en = slow_en_ff;

   // ***************************************************************
   // Block power enables
   // ***************************************************************
   // Each analog block has its own enable, all forced off in sleep;
   // the bandgap is outside this control and always stays on
   assign o_analog_on     = an_ff[AN_NBLK-1:0] & {AN_NBLK{~o_sleep}};
   assign o_supervisor_on = psc_ff[PSC_SUPE];
   assign o_slow_osc_on   = psc_ff[PSC_OSC32E];
   assign o_wake_logic_on = psc_ff[PSC_WAKEE] | ~o_sleep;

   // ***************************************************************
   // User I/O pin drivers
   // ***************************************************************
   // Inputs keep their pull-up; pump rail follows the analog supply
   // only while the pump doubler is off
   assign o_pin_o         = pout_ff;
   assign o_pin_oe        = pin_drv;
   assign o_pin_pullup    = ~pin_drv;
   assign o_pin_avdd_rail = pin_drv & rail_ff & {NPIN{~psc_ff[PSC_CPE]}};

   // ***************************************************************
   // Converter code format
   // ***************************************************************
   logic              adc_vld_ff;
   logic [ADC_W-1:0]  adc_ff;
   logic [ADC_W-1:0]  uni_code;
   logic [ADC_W-1:0]  bip_code;

   // Negative inputs clamp to zero in unipolar mode
   assign uni_code = i_adc_value[ADC_IW-1] ? UNI_ZERO : i_adc_value[ADC_W-1:0];
   // Halving keeps the full bipolar span in sixteen bits
   assign bip_code = i_adc_value[ADC_IW-1:1];

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         adc_vld_ff <= 1'b0;
         adc_ff     <= '0;
      end else begin
         adc_vld_ff <= i_adc_vld;
         if (i_adc_vld) adc_ff <= an_ff[AN_BIPOLAR] ? bip_code : uni_code;
      end
   end

   assign o_adc_vld  = adc_vld_ff;
   assign o_adc_code = adc_ff;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   sleep_or_a: assert property (##1 o_sleep == (shutdown_flag_ff || $past(pin_sleep_w)))
      else $error("sleep state is not pin OR flag");
   sleep_cmd_a: assert property (i_sleep_cmd_wr |=> shutdown_flag_ff && o_sleep)
      else $error("sleep command did not sleep");
   cfg_sleep_a: assert property (i_sleep_cfg_wr && i_sleep_request_bit |=> shutdown_flag_ff)
      else $error("sleep request bit did not set flag");
   pin_keeps_a: assert property (pin_sleep_w && !set_req |=> shutdown_flag_ff == $past(shutdown_flag_ff))
      else $error("pin sleep changed the flag");
   normal_cmd_a: assert property (i_normal_cmd_wr && !pin_sleep_w && !set_req
                                  |=> !shutdown_flag_ff)
      else $error("normal command did not clear flag");
   wake_exit_a: assert property (wake_evt && o_sleep && !pin_sleep_w && !set_req
                                 |=> !o_sleep)
      else $error("wake did not leave sleep");
   wake_rec_a: assert property (wake_evt && !o_sleep && !pin_sleep_w && !set_req
                                |=> !o_sleep && status_ff[ST_WAKE])
      else $error("wake in normal mode misbehaved");
   rst_out_a: assert property (i_watchdog_expired || xtal_s || !slow_s |=> !o_reset_n)
      else $error("reset output not pulled low");
   low_irq_a: assert property (status_ff[ST_LOWDV] && mask_ff[ST_LOWDV] && !psc_ff[PSC_RESET_OUTPUT_ENABLE]
                               |=> o_irq)
      else $error("low supply interrupt missing");
   clk_gate_a: assert property ($rose(o_clk_out_en) |-> $past(ck_ff) == CK_RUN)
      else $error("clock output before timeout");
   adc_fmt_a: assert property (i_adc_vld && !an_ff[AN_BIPOLAR] && i_adc_value[ADC_IW-1]
                               |=> o_adc_code == UNI_ZERO)
      else $error("unipolar negative not clamped");
   sleep_pwr_a: assert property (o_sleep |-> o_analog_on == '0 && !o_clk_out_en ##0 1)
      else $error("block powered in sleep");

   pin_sleep_c: cover property (!o_sleep ##1 pin_sleep_w ##1 o_sleep);
   wake_exit_c: cover property (o_sleep && wake_evt ##1 !o_sleep);
   clk_start_c: cover property ($rose(o_clk_out_en));
   low_irq_c:   cover property (status_ff[ST_LOWDV] && o_irq);

endmodule
`default_nettype wire

//--- verilog/pmr_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Two-stage synchroniser with edge detection
// ***************************************************************
module pmr_sync_edge #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rstn,
   // Asynchronous inputs
   input  wire logic [W-1:0] i_async,
   // Synchronised outputs
   pmr_sync_if.src           o_sync
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] prev_ff;

   // Reset to the idle level so no false edge follows release
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
         prev_ff <= RST_VAL;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // The first stage feeds no logic; edges compare the second stage with its delayed copy
   assign o_sync.lvl  = sync_ff;
   assign o_sync.rise = sync_ff & ~prev_ff;
   assign o_sync.fall = ~sync_ff & prev_ff;

endmodule
`default_nettype wire
